// ### rtl/rrs_pkg.sv
// Constants shared by the rotate-right and sleep execution block.
// Assumes a 40 MHz core clock split into four phases per instruction cycle.
package rrs_pkg;

  // **************************************************
  // Instruction encodings
  // **************************************************
  localparam logic [5:0]  OPC_ROTATE_RIGHT = 6'h0C;     // Bits 13:8 of the rotate-right op
  localparam logic [13:0] OPC_SLEEP        = 14'h0063;  // Whole word of the low-power op
  localparam int unsigned DEST_BIT         = 7;         // Destination select position

  // **************************************************
  // Register offsets (byte addresses)
  // **************************************************
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_ACC    = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [11:0] ADDR_WDOG   = 12'h00C;
  localparam logic [11:0] ADDR_FILE   = 12'h200;  // 128 words, one byte each

  // **************************************************
  // Field positions
  // **************************************************
  localparam int unsigned CTRL_WAKE_BIT   = 0;
  localparam int unsigned ST_CARRY_BIT    = 0;
  localparam int unsigned ST_TIMEOUT_BIT  = 1;
  localparam int unsigned ST_PWRDOWN_BIT  = 2;
  localparam int unsigned ST_ASLEEP_BIT   = 3;

  // **************************************************
  // Reset values and counts
  // **************************************************
  localparam logic [7:0]  ACC_RESET        = 8'h00;
  localparam logic        TIMEOUT_RESET    = 1'b1;
  localparam logic        PWRDOWN_RESET    = 1'b1;
  localparam logic [7:0]  WDOG_CLEAR       = 8'h00;
  localparam logic [7:0]  PRESCALE_CLEAR   = 8'h00;
  localparam logic [1:0]  PHASES_PER_CYCLE = 2'h3;  // Last phase index

  typedef enum {PH_Q1, PH_Q2, PH_Q3, PH_Q4} rrs_phase_t;

endpackage

// ### rtl/rrs_exec.sv
// Execution logic for the rotate-right-through-carry and low-power instructions.
// Assumes the fetch stage presents an opcode during phase one, and an APB master
// on the same clock reaches the working registers and the file registers.
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ps

// Operation
// - Rotate right op shifts file register right; carry enters MSB, LSB becomes carry.
// - Destination bit clear: result goes to accumulator, file register unchanged.
// - Destination bit set: result written back to the same file register.
// - Low-power op loads zero into watchdog counter and clears its prescaler.
// - Low-power op sets time-out flag, clears power-down flag, sets asleep, touches nothing else.
module rrs_exec
  import rrs_pkg::*;
#(
  parameter int unsigned FILE_DEPTH = 128
) (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  input  wire logic [13:0] instr_in,
  input  wire logic        instr_valid_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  output logic             asleep_out,
  output logic             carry_out,
  output logic       [1:0] phase_out
);
  import rrs_pkg::*;

  // **************************************************
  // State
  // **************************************************
  logic [7:0]  file_mem [FILE_DEPTH];
  rrs_phase_t  phase_q,  phase_d;
  logic [13:0] op_q;
  logic [7:0]  rd_q;
  logic [7:0]  res_q;
  logic        cout_q;
  logic [7:0]  acc_q;
  logic        carry_q;
  logic        timeout_status_flag_q;
  logic        powerdown_status_flag_q;
  logic        asleep_q;
  logic [7:0]  watchdog_counter_q;
  logic [7:0]  prescale_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [1:0]  phase_code_q;

  // **************************************************
  // Instruction decode
  // **************************************************
  // Decoded kind of the latched opcode
  wire         is_rotate  = (op_q[13:8] == OPC_ROTATE_RIGHT);
  wire         is_sleep   = (op_q == OPC_SLEEP);
  wire         dest_file  = op_q[DEST_BIT];
  wire  [6:0]  file_addr  = op_q[6:0];
  wire         at_q1      = (phase_q == PH_Q1);
  wire         at_q2      = (phase_q == PH_Q2);
  wire         at_q3      = (phase_q == PH_Q3);
  wire         at_q4      = (phase_q == PH_Q4);
  // Phase-four write strobes
  wire         rot_commit   = at_q4 && is_rotate && !asleep_q;
  wire         sleep_commit = at_q4 && is_sleep && !asleep_q;
  wire         rot_to_file  = rot_commit && dest_file;
  wire         rot_to_acc   = rot_commit && !dest_file;

  // **************************************************
  // Watchdog
  // **************************************************
  wire         prescale_wrap = (prescale_q == 8'hFF);
  wire         wdog_wrap     = prescale_wrap && (watchdog_counter_q == 8'hFF);

  // **************************************************
  // APB decode
  // **************************************************
  wire         apb_access = psel_in && penable_in && !pready_q;
  wire         apb_done   = psel_in && penable_in && pready_q;
  wire         hit_ctrl   = (paddr_in == ADDR_CTRL);
  wire         hit_acc    = (paddr_in == ADDR_ACC);
  wire         hit_status = (paddr_in == ADDR_STATUS);
  wire         hit_wdog   = (paddr_in == ADDR_WDOG);
  wire         hit_file   = (paddr_in[11:9] == ADDR_FILE[11:9]) && (paddr_in[1:0] == 2'h0);
  wire  [6:0]  apb_index  = paddr_in[8:2];
  wire         mapped     = hit_ctrl || hit_acc || hit_status || hit_wdog || hit_file;
  wire         apb_wr     = apb_done && pwrite_in && !pslverr_q;
  wire  [7:0]  status_byte;
  logic [31:0] read_mux;

  // Status byte as software sees it
  // Only the carry is writable; time-out, power-down and asleep
  // are read-only views of the core state.
  assign status_byte = {4'h0, asleep_q, powerdown_status_flag_q, timeout_status_flag_q, carry_q};

  // Read data selection
  always_comb begin
    read_mux = 32'h0000_0000;
    if (hit_ctrl) begin
      read_mux = {31'h0000_0000, asleep_q};
    end else if (hit_acc) begin
      read_mux = {24'h00_0000, acc_q};
    end else if (hit_status) begin
      read_mux = {24'h00_0000, status_byte};
    end else if (hit_wdog) begin
      read_mux = {16'h0000, prescale_q, watchdog_counter_q};
    end else if (hit_file) begin
      read_mux = {24'h00_0000, file_mem[apb_index]};
    end
  end

  // **************************************************
  // Phase sequencer
  // **************************************************
  // Four phases per cycle; the clock keeps running while asleep, the phase is held in Q1 and the opcode frozen
  // The sequencer parks in Q1 while asleep so that, on wake, the
  // core resumes at the start of a fresh instruction cycle rather
  // than in the middle of one.
  always_comb begin
    phase_d = phase_q;
    case (phase_q)
      PH_Q1: phase_d = PH_Q2;
      PH_Q2: phase_d = PH_Q3;
      PH_Q3: phase_d = PH_Q4;
      PH_Q4: phase_d = PH_Q1;
      default: phase_d = PH_Q1;
    endcase
    if (asleep_q) begin
      phase_d = PH_Q1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      phase_q      <= PH_Q1;
      phase_code_q <= 2'h0;
    end else begin
      phase_q      <= phase_d;
      phase_code_q <= 2'(phase_d);
    end
  end

  // **************************************************
  // Datapath
  // **************************************************
  // Timing of one instruction cycle, counted in core clocks:
  //   edge ending Q1 - opcode latched into op_q
  //   edge ending Q2 - addressed file register copied into rd_q
  //   edge ending Q3 - rotated value and new carry prepared
  //   edge ending Q4 - result and carry committed, or sleep entered
  // The opcode stays in op_q for the whole cycle, so the file
  // address used for the read in Q2 and the write in Q4 is the same.
  // A missing instruction is latched as all zeros, which decodes
  // as neither op and so acts as a no-op.
  // While asleep the opcode register is frozen; the first Q1 after
  // wake loads a fresh opcode before any commit can happen.
  //
  // Decode in phase one
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      op_q <= 14'h0000;
    end else if (at_q1 && !asleep_q) begin
      op_q <= instr_valid_in ? instr_in : 14'h0000;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rd_q   <= 8'h00;
      res_q  <= 8'h00;
      cout_q <= 1'b0;
    end else begin
      if (at_q2) begin
        rd_q <= file_mem[file_addr];
      end
      if (at_q3) begin
        res_q  <= {carry_q, rd_q[7:1]};
        cout_q <= rd_q[0];
      end
    end
  end

  // File register write port, instruction first
  // A software write that lands on the same edge as a rotate
  // commit to a file register is dropped; the instruction owns
  // the single write port in Q4. Software should avoid writing
  // file registers while instructions are running.
  // The array is not reset; its contents are unknown until written.
  always_ff @(posedge sys_clk_in) begin
    if (rot_to_file) begin
      file_mem[file_addr] <= res_q;
    end else if (apb_wr && hit_file) begin
      file_mem[apb_index] <= pwdata_in[7:0];
    end
  end

  // Accumulator and carry update
  // The commit beats a software write in the same edge, so an
  // instruction result is never lost to a racing bus access.
  // The carry read in Q3 is the value that stood at that edge;
  // a software carry write after Q3 is overwritten by the commit.
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      acc_q   <= ACC_RESET;
      carry_q <= 1'b0;
    end else begin
      if (rot_to_acc) begin
        acc_q <= res_q;
      end else if (apb_wr && hit_acc) begin
        acc_q <= pwdata_in[7:0];
      end
      if (rot_commit) begin
        carry_q <= cout_q;
      end else if (apb_wr && hit_status) begin
        carry_q <= pwdata_in[ST_CARRY_BIT];
      end
    end
  end

  // Enter the low-power state in phase four; APB wake or watchdog leaves it
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      asleep_q <= 1'b0;
    end else if (sleep_commit) begin
      asleep_q <= 1'b1;
    end else if (wdog_wrap || (apb_wr && hit_ctrl && pwdata_in[CTRL_WAKE_BIT])) begin
      asleep_q <= 1'b0;
    end
  end

  // Status flags changed by the low-power op
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      timeout_status_flag_q   <= TIMEOUT_RESET;
      powerdown_status_flag_q <= PWRDOWN_RESET;
    end else if (sleep_commit) begin
      timeout_status_flag_q   <= 1'b1;
      powerdown_status_flag_q <= 1'b0;
    end else if (wdog_wrap) begin
      timeout_status_flag_q   <= 1'b0;  // Low means a time-out happened
    end
  end

  // Watchdog and prescaler, cleared by the low-power op
  // The prescaler counts every clock, asleep or awake, and the counter steps when it wraps. A wrap of
  // the counter and its prescaler together marks a time-out: the
  // time-out flag goes low and the core wakes. The low-power op
  // restarts both from zero, so sleep always gets the full span.
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      prescale_q         <= PRESCALE_CLEAR;
      watchdog_counter_q <= WDOG_CLEAR;
    end else if (sleep_commit) begin
      prescale_q         <= PRESCALE_CLEAR;
      watchdog_counter_q <= WDOG_CLEAR;
    end else begin
      prescale_q <= prescale_q + 8'h01;
      if (prescale_wrap) begin
        watchdog_counter_q <= watchdog_counter_q + 8'h01;
      end
    end
  end

  // **************************************************
  // APB answer
  // **************************************************
  // One wait state, then data and error from flops
  // The first access cycle registers the request; ready, error
  // and read data appear together in the second access cycle
  // and ready drops again the cycle after, even if the master
  // keeps enable high. A write takes effect at the ready edge,
  // and an unmapped address answers with an error and no write.
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= apb_access;
      pslverr_q <= apb_access && !mapped;
      if (apb_access) begin
        prdata_q <= read_mux;
      end
    end
  end

  // Outputs straight from flops
  assign prdata_out  = prdata_q;
  assign pready_out  = pready_q;
  assign pslverr_out = pslverr_q;
  assign asleep_out  = asleep_q;
  assign carry_out   = carry_q;
  assign phase_out   = phase_code_q;

endmodule

// ### tb/rrs_exec_properties.sv
// Checker for the rotate and sleep execution block, bound to its ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module rrs_exec_properties
  import rrs_pkg::*;
(
  input wire logic        sys_clk_in,
  input wire logic        rst_in,
  input wire logic [13:0] instr_in,
  input wire logic        instr_valid_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        asleep_out,
  input wire logic        carry_out,
  input wire logic [1:0]  phase_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // Instruction taken at the end of phase one
  wire take_w = instr_valid_in && (phase_out == 2'h0) && !asleep_out;
  // ***************
  // Properties
  // ***************
  property p_rdy_pulse; pready_out |=> !pready_out; endproperty
  property p_rdy_wait; psel_in && penable_in && !$past(penable_in) |-> !pready_out ##1 pready_out; endproperty
  property p_err_rdy; pslverr_out |-> pready_out; endproperty
  property p_phase_step;
    !asleep_out && !$past(asleep_out) && !$past(rst_in) |-> phase_out == 2'($past(phase_out) + 2'h1);
  endproperty
  property p_sleep_phase; asleep_out |-> phase_out == 2'h0; endproperty
  property p_sleep_entry; take_w && instr_in == OPC_SLEEP |-> ##3 !asleep_out ##1 asleep_out; endproperty
  property p_carry_cause;
    $changed(carry_out) |-> $past(phase_out) == 2'h3 || $past(pready_out && pwrite_in && paddr_in == ADDR_STATUS);
  endproperty
  property p_sleep_carry; $rose(asleep_out) |-> $stable(carry_out); endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready longer than one cycle");
  a_rdy_wait: assert property (p_rdy_wait) else $error("ready not after one wait state");
  a_err_rdy: assert property (p_err_rdy) else $error("error without ready");
  a_phase_step: assert property (p_phase_step) else $error("phase did not advance");
  a_sleep_phase: assert property (p_sleep_phase) else $error("phase moves while asleep");
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered in phase four");
  a_carry_cause: assert property (p_carry_cause) else $error("carry changed outside a commit");
  a_sleep_carry: assert property (p_sleep_carry) else $error("sleep changed the carry");
  c_sleep: cover property ($rose(asleep_out));
  c_err: cover property (pslverr_out);
  c_rot: cover property (take_w && instr_in[13:8] == OPC_ROTATE_RIGHT);
endmodule
bind rrs_exec rrs_exec_properties u_props (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .instr_in(instr_in),
  .instr_valid_in(instr_valid_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
  .paddr_in(paddr_in), .pready_out(pready_out), .pslverr_out(pslverr_out), .asleep_out(asleep_out),
  .carry_out(carry_out), .phase_out(phase_out));

// ### tb/test_rrs_exec.sv
// Testbench for the rotate and sleep execution block.
// Drives instructions and APB transfers itself; no partner model.
`timescale 1ns/1ps
module test_rrs_exec;
  import rrs_pkg::*;
  logic        sys_clk_in, rst_in, instr_valid_in, psel_in, penable_in, pwrite_in;
  logic [13:0] instr_in;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, rd;
  logic        pready_out, pslverr_out, asleep_out, carry_out, err;
  logic [1:0]  phase_out;
  int          num_errors = 0;
  int          compares   = 0;
  rrs_exec dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .instr_in(instr_in), .instr_valid_in(instr_valid_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out), .asleep_out(asleep_out),
    .carry_out(carry_out), .phase_out(phase_out));
  // Clock of 25 ns
  initial begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One APB transfer, held until ready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    psel_in   <= 1'b1;
    pwrite_in <= w;
    paddr_in  <= a;
    pwdata_in <= d;
    @(posedge sys_clk_in);
    penable_in <= 1'b1;
    // Ready sampled at the rising edge; data and error taken at that same edge
    do @(posedge sys_clk_in); while (pready_out !== 1'b1);
    rd  = prdata_out;
    err = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
  endtask
  // One instruction presented during phase one
  task automatic exec(input logic [13:0] op);
    if (!asleep_out) do @(negedge sys_clk_in); while (phase_out !== 2'h3);
    @(posedge sys_clk_in);
    instr_in       <= op;
    instr_valid_in <= 1'b1;
    @(posedge sys_clk_in);
    instr_valid_in <= 1'b0;
    repeat (5) @(posedge sys_clk_in);
  endtask
  task automatic tally_and_finish;
    $display("Compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge sys_clk_in);
    num_errors++;
    tally_and_finish();
  end
  // ***************
  // Main sequence
  // ***************
  initial begin
    {rst_in, instr_valid_in, psel_in, penable_in, pwrite_in} = 5'h10;
    instr_in  = 14'h0000;
    paddr_in  = 12'h000;
    pwdata_in = 32'h0;
    repeat (6) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    apb(1'b0, ADDR_STATUS, 32'h0); check("status reset", rd, 32'h6);
    apb(1'b1, ADDR_FILE + 12'h014, 32'hB3);
    apb(1'b1, ADDR_FILE + 12'h1FC, 32'h02);
    apb(1'b1, ADDR_STATUS, 32'h0);
    exec({OPC_ROTATE_RIGHT, 1'b0, 7'd5});
    check("carry", carry_out, 32'h1);
    apb(1'b0, ADDR_ACC, 32'h0); check("acc", rd, 32'h59);
    apb(1'b0, ADDR_FILE + 12'h014, 32'h0); check("file 5", rd, 32'hB3);
    exec({OPC_ROTATE_RIGHT, 1'b1, 7'd5});
    apb(1'b0, ADDR_FILE + 12'h014, 32'h0); check("file 5", rd, 32'hD9);
    apb(1'b0, ADDR_ACC, 32'h0); check("acc", rd, 32'h59);
    exec({OPC_ROTATE_RIGHT, 1'b1, 7'd127});
    apb(1'b0, ADDR_FILE + 12'h1FC, 32'h0); check("file 127", rd, 32'h81);
    check("carry", carry_out, 32'h0);
    repeat (300) @(posedge sys_clk_in);
    exec(OPC_SLEEP);
    check("asleep", asleep_out, 32'h1);
    apb(1'b0, ADDR_WDOG, 32'h0); check("watchdog", rd[7:0], 32'h0);
    check("prescaler small", rd[15:8] < 8'h10, 32'h1);
    apb(1'b0, ADDR_STATUS, 32'h0); check("status", rd, 32'hA);
    exec({OPC_ROTATE_RIGHT, 1'b0, 7'd127});
    apb(1'b0, ADDR_ACC, 32'h0); check("acc asleep", rd, 32'h59);
    check("phase asleep", phase_out, 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h1);
    // Wake lands at the ready edge; look once it has settled
    @(negedge sys_clk_in);
    check("woken", asleep_out, 32'h0);
    apb(1'b0, 12'h100, 32'h0); check("unmapped err", err, 32'h1);
    check("unmapped data", rd, 32'h0);
    tally_and_finish();
  end
endmodule
